// >>> hw/bic_ctrl.sv
`timescale 1ns/1ps
`include "bic_map.svh"

module bic_ctrl
  import bic_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // register port from the control coprocessor
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // bus cycle qualifiers from the bus unit
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  // strobes and shared pins
  output logic             memory_strobe_out_n,
  output logic             io_strobe_out_n,
  output logic             external_data_enable_out_n,
  input  wire logic [1:0]  shared_branch_pins_in,
  output logic      [1:0]  shared_branch_pins_out,
  output logic      [1:0]  shared_branch_pins_oe,
  output logic      [1:0]  branch_cond_in
);

  //////////////////////////////////////////////////////////////////////////
  // strobe decode shared by all three strobe fields
  function automatic logic stb_on(input logic [1:0] mode,
                                  input logic rd, input logic wr);
    case (bic_stb_mode_t'(mode))
      BIC_STB_OFF:   stb_on = 1'b0;
      BIC_STB_WRITE: stb_on = wr;
      BIC_STB_READ:  stb_on = rd;
      BIC_STB_BOTH:  stb_on = rd | wr;
      default:       stb_on = 1'b0;
    endcase
  endfunction : stb_on

  //////////////////////////////////////////////////////////////////////////
  // control word
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [1:0]  sbp_s1_r;
  logic [1:0]  sbp_s1_nxt;
  logic [1:0]  sbp_s2_r;
  logic [1:0]  sbp_s2_nxt;
  logic        mem_n_r;
  logic        mem_n_nxt;
  logic        io_n_r;
  logic        io_n_nxt;
  logic        ext_n_r;
  logic        ext_n_nxt;
  logic        pins_out;

  // writes are masked so reserved bits keep their fixed values; a set
  // lock freezes the word until the next reset
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr && !ctrl_r[`BIC_LOCK_BIT]) begin
      ctrl_nxt = (reg_wdata & `BIC_RW_MASK) | `BIC_HI_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_r <= `BIC_RESET_VALUE;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // read back the live word
  assign reg_rdata = ctrl_r;

  //////////////////////////////////////////////////////////////////////////
  // shared pins: input synchroniser and direction
  assign pins_out = ctrl_r[`BIC_BR_BIT];
  assign shared_branch_pins_oe = {2{pins_out}};
  // pins are read as branch inputs only while not driven
  assign branch_cond_in = pins_out ? 2'h0 : sbp_s2_r;

  always_comb begin
    sbp_s1_nxt = shared_branch_pins_in;
    sbp_s2_nxt = sbp_s1_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // strobes, registered so the pins carry no decode glitches; one cycle of
  // lag behind the qualifiers is covered by the software settle time
  always_comb begin
    mem_n_nxt = !stb_on(ctrl_r[`BIC_MEM_LSB +: 2], bus_rd, bus_wr);
    io_n_nxt  = !(pins_out &&
                  stb_on(ctrl_r[`BIC_IO_LSB +: 2], bus_rd, bus_wr));
    ext_n_nxt = !(pins_out &&
                  stb_on(ctrl_r[`BIC_EXT_LSB +: 2], bus_rd, bus_wr));
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sbp_s1_r <= 2'h0;
      sbp_s2_r <= 2'h0;
      mem_n_r  <= 1'b1;
      io_n_r   <= 1'b1;
      ext_n_r  <= 1'b1;
    end else begin
      sbp_s1_r <= sbp_s1_nxt;
      sbp_s2_r <= sbp_s2_nxt;
      mem_n_r  <= mem_n_nxt;
      io_n_r   <= io_n_nxt;
      ext_n_r  <= ext_n_nxt;
    end
  end

  assign memory_strobe_out_n        = mem_n_r;
  assign io_strobe_out_n            = io_n_r;
  assign external_data_enable_out_n = ext_n_r;
  assign shared_branch_pins_out     = {io_n_r, ext_n_r};

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_locked_write;
    ctrl_r[`BIC_LOCK_BIT] && reg_wr;
  endsequence

  // a write that the open register must take
  sequence s_open_write;
    !ctrl_r[`BIC_LOCK_BIT] && reg_wr;
  endsequence

  // the locking write itself, followed by a further attempt
  sequence s_lock_then_write;
    (!ctrl_r[`BIC_LOCK_BIT] && reg_wr && reg_wdata[`BIC_LOCK_BIT]) ##1 reg_wr;
  endsequence

  // no bus cycle is in progress
  sequence s_bus_idle;
    !bus_rd && !bus_wr;
  endsequence

  AST_RESET_VALUE: assert property (@(posedge clock)
    sys_rst |=> ctrl_r == `BIC_RESET_VALUE)
    else $error("control word wrong after reset");

  AST_LOCK_HOLDS: assert property (@(posedge clock) disable iff (sys_rst)
    s_locked_write |=> $stable(ctrl_r))
    else $error("locked word changed on write");

  AST_RSVD_HI: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 ctrl_r[`BIC_RSVD_HI_BIT])
    else $error("reserved high bit not one");

  AST_RSVD_LO: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 (ctrl_r & ~`BIC_RW_MASK & ~`BIC_HI_MASK) == 32'h0)
    else $error("reserved low bits not zero");

  AST_MEM_WRITE_ONLY: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_MEM_LSB +: 2] == 2'h1 && bus_rd && !bus_wr
    |=> memory_strobe_out_n)
    else $error("memory strobe on read in write-only mode");

  AST_MEM_FOLLOW: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_MEM_LSB +: 2] == 2'h3 && (bus_rd || bus_wr)
    |=> !memory_strobe_out_n)
    else $error("memory strobe missing in both mode");

  AST_MEM_OFF: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_MEM_LSB +: 2] == 2'h0 |=> memory_strobe_out_n)
    else $error("memory strobe active while off");

  AST_EXT_IGNORED: assert property (@(posedge clock) disable iff (sys_rst)
    !pins_out |=> external_data_enable_out_n && io_strobe_out_n)
    else $error("strobe driven while pins are inputs");

  AST_EXT_READ: assert property (@(posedge clock) disable iff (sys_rst)
    pins_out && ctrl_r[`BIC_EXT_LSB +: 2] == 2'h2 && bus_rd
    |=> !external_data_enable_out_n)
    else $error("data enable missing on read");

  AST_IDLE_HIGH: assert property (@(posedge clock) disable iff (sys_rst)
    !bus_rd && !bus_wr |=> memory_strobe_out_n &&
                           external_data_enable_out_n)
    else $error("strobe active between cycles");

  // reset values of the individual fields
  AST_LOCK_RESET: assert property (@(posedge clock)
    sys_rst |=> !ctrl_r[`BIC_LOCK_BIT])
    else $error("lock bit set after reset");

  AST_MEM_RESET_FIELD: assert property (@(posedge clock)
    sys_rst |=> ctrl_r[`BIC_MEM_LSB +: 2] == `BIC_MEM_RST)
    else $error("memory strobe field wrong after reset");

  AST_EXT_RESET_FIELD: assert property (@(posedge clock)
    sys_rst |=> ctrl_r[`BIC_EXT_LSB +: 2] == `BIC_EXT_RST)
    else $error("data enable field wrong after reset");

  AST_BR_RESET: assert property (@(posedge clock)
    sys_rst |=> !ctrl_r[`BIC_BR_BIT])
    else $error("shared pins not inputs after reset");

  // register writes, lock and read back
  AST_WRITE_TAKEN: assert property (@(posedge clock) disable iff (sys_rst)
    s_open_write |=> ctrl_r ==
      (($past(reg_wdata) & `BIC_RW_MASK) | `BIC_HI_MASK))
    else $error("open write not stored");

  AST_READBACK: assert property (@(posedge clock)
    reg_rdata == ctrl_r)
    else $error("read back differs from control word");

  AST_LOCK_STICKY: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_LOCK_BIT] |=> ctrl_r[`BIC_LOCK_BIT])
    else $error("lock bit cleared without reset");

  AST_LOCK_SEQ: assert property (@(posedge clock) disable iff (sys_rst)
    s_lock_then_write |=> $stable(ctrl_r))
    else $error("write after locking changed the word");

  // memory strobe modes not covered above
  AST_MEM_WRITE_DRIVE: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_MEM_LSB +: 2] == 2'h1 && bus_wr
    |=> !memory_strobe_out_n)
    else $error("memory strobe missing on write");

  AST_MEM_READ_DRIVE: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_MEM_LSB +: 2] == 2'h2 && bus_rd
    |=> !memory_strobe_out_n)
    else $error("memory strobe missing on read");

  AST_MEM_READ_ONLY: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_MEM_LSB +: 2] == 2'h2 && bus_wr && !bus_rd
    |=> memory_strobe_out_n)
    else $error("memory strobe on write in read-only mode");

  // data enable modes; off, write and both are checked only while the shared pins are outputs
  AST_EXT_OFF: assert property (@(posedge clock) disable iff (sys_rst)
    pins_out && ctrl_r[`BIC_EXT_LSB +: 2] == 2'h0
    |=> external_data_enable_out_n)
    else $error("data enable active while off");

  AST_EXT_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
    pins_out && ctrl_r[`BIC_EXT_LSB +: 2] == 2'h1 && bus_wr
    |=> !external_data_enable_out_n)
    else $error("data enable missing on write");

  AST_EXT_WRITE_ONLY: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_EXT_LSB +: 2] == 2'h1 && bus_rd && !bus_wr
    |=> external_data_enable_out_n)
    else $error("data enable on read in write-only mode");

  AST_EXT_READ_ONLY: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_r[`BIC_EXT_LSB +: 2] == 2'h2 && bus_wr && !bus_rd
    |=> external_data_enable_out_n)
    else $error("data enable on write in read-only mode");

  AST_EXT_BOTH: assert property (@(posedge clock) disable iff (sys_rst)
    pins_out && ctrl_r[`BIC_EXT_LSB +: 2] == 2'h3 && (bus_rd || bus_wr)
    |=> !external_data_enable_out_n)
    else $error("data enable missing in both mode");

  // shared pin direction and contents
  AST_PINS_DRIVE: assert property (@(posedge clock) disable iff (sys_rst)
    pins_out |-> shared_branch_pins_out ==
      {io_strobe_out_n, external_data_enable_out_n})
    else $error("shared pins do not carry the strobes");

  AST_COND_MASKED: assert property (@(posedge clock) disable iff (sys_rst)
    pins_out |-> branch_cond_in == 2'h0)
    else $error("branch inputs seen while pins drive");

  // strobes go low only for a sampled bus cycle; a stray low after a
  // config change would otherwise reach the pins unnoticed
  AST_IDLE_IO: assert property (@(posedge clock) disable iff (sys_rst)
    s_bus_idle |=> io_strobe_out_n)
    else $error("io strobe active between cycles");

  AST_MEM_IN_CYCLE: assert property (@(posedge clock) disable iff (sys_rst)
    !memory_strobe_out_n |-> $past(bus_rd || bus_wr))
    else $error("memory strobe low outside a cycle");

  AST_EXT_IN_CYCLE: assert property (@(posedge clock) disable iff (sys_rst)
    !external_data_enable_out_n |-> $past(bus_rd || bus_wr))
    else $error("data enable low outside a cycle");

  AST_IO_IN_CYCLE: assert property (@(posedge clock) disable iff (sys_rst)
    !io_strobe_out_n |-> $past(bus_rd || bus_wr))
    else $error("io strobe low outside a cycle");

endmodule : bic_ctrl

// >>> hw/bic_map.svh
`ifndef BIC_MAP_SVH
`define BIC_MAP_SVH
// bit positions inside the bus interface control word
`define BIC_LOCK_BIT        31
`define BIC_RSVD_HI_BIT     30
`define BIC_BR_BIT          28
`define BIC_MEM_LSB         26
`define BIC_EXT_LSB         24
`define BIC_IO_LSB          22
// reset values of the fields
`define BIC_MEM_RST         2'h1
`define BIC_EXT_RST         2'h3
`define BIC_IO_RST          2'h3
// bits that hold state; the rest are reserved
`define BIC_RW_MASK         32'h9ffc_0000
`define BIC_HI_MASK         32'h4000_0000
`define BIC_RESET_VALUE     32'h47c0_0000
`endif

// >>> hw/bic_pkg.sv
package bic_pkg;
  // strobe configuration codes shared by all strobe fields
  typedef enum logic [1:0] {
    BIC_STB_OFF   = 2'h0,
    BIC_STB_WRITE = 2'h1,
    BIC_STB_READ  = 2'h2,
    BIC_STB_BOTH  = 2'h3
  } bic_stb_mode_t;
endpackage : bic_pkg

// >>> tb/bic_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, v); end end
module bic_ctrl_test;
  // clock, reset and register port
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  // bus qualifiers, strobes and pins
  logic        bus_rd = 1'b0;
  logic        bus_wr = 1'b0;
  logic        mem_n, io_n, ext_n;
  logic [1:0]  pin_in, pin_out, pin_oe, cond;
  logic [1:0]  cond_lvl = 2'h2;
  int          err_total = 0;
  int          compares = 0;
  bic_ctrl DUT (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .memory_strobe_out_n(mem_n), .io_strobe_out_n(io_n),
    .external_data_enable_out_n(ext_n), .shared_branch_pins_in(pin_in),
    .shared_branch_pins_out(pin_out), .shared_branch_pins_oe(pin_oe),
    .branch_cond_in(cond));
  bic_far_end far (.pins_out(pin_out), .pins_oe(pin_oe),
    .cond_lvl(cond_lvl), .pins_in(pin_in));
  initial begin
    forever #5 clock = ~clock;
  end
  // expected active-low strobe level for a mode and a cycle kind
  function automatic logic act(logic [1:0] m, logic r, logic w);
    return ~((m[0] & w) | (m[1] & r));
  endfunction : act
  function automatic logic [31:0] word(logic b, logic [1:0] m, logic [1:0] e);
    return 32'h40c0_0000 | {3'h0, b, m, e, 24'h0};
  endfunction : word
  task automatic wr_word(input logic [31:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr_word
  // one sampled bus cycle; strobes are registered so look one edge later
  task automatic bus_cycle(input logic r, input logic w);
    @(posedge clock);
    bus_rd <= r;
    bus_wr <= w;
    @(posedge clock);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    #1;
  endtask : bus_cycle
  task automatic sc_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    `CHK("rdata", 32'h47c0_0000, reg_rdata)
    `CHK("strobes", 3'h7, {mem_n, io_n, ext_n})
    `CHK("oe", 2'h0, pin_oe)
    `CHK("cond", 2'h2, cond)
  endtask : sc_reset
  task automatic sc_mem;
    for (int m = 0; m < 4; m++) begin
      wr_word(word(1'b0, m[1:0], 2'h3));
      repeat (10) @(posedge clock); // settle time before relying on it
      for (int k = 0; k < 4; k++) begin
        bus_cycle(k[1], k[0]);
        `CHK("mem", act(m[1:0], k[1], k[0]), mem_n)
        `CHK("ext_off", 1'b1, ext_n)
      end
    end
  endtask : sc_mem
  task automatic sc_ext;
    for (int e = 0; e < 4; e++) begin
      wr_word(word(1'b1, 2'h1, e[1:0]));
      `CHK("readback", word(1'b1, 2'h1, e[1:0]), reg_rdata)
      for (int k = 0; k < 4; k++) begin
        bus_cycle(k[1], k[0]);
        `CHK("ext", act(e[1:0], k[1], k[0]), ext_n)
        `CHK("pins", {act(2'h3, k[1], k[0]), ext_n}, pin_out)
        `CHK("oe_cond", 4'hc, {pin_oe, cond})
      end
    end
  endtask : sc_ext
  task automatic sc_lock;
    wr_word(32'h7fff_ffff);
    `CHK("rsvd", 32'h5ffc_0000, reg_rdata)
    wr_word(32'h8000_0000);
    wr_word(32'h1400_0000);
    `CHK("locked", 32'hc000_0000, reg_rdata)
    sc_reset();
  endtask : sc_lock
  task automatic close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // watchdog: a hang counts as a mismatch
  initial begin
    #500000;
    err_total++;
    close_out();
  end
  initial begin
    sc_reset();
    sc_mem();
    sc_ext();
    sc_lock();
    close_out();
  end
endmodule : bic_ctrl_test

// >>> tb/bic_far_end.sv
`timescale 1ns/1ps
// far side of the shared pins: sets condition levels while pins are inputs
module bic_far_end (
  // pin view
  input  wire logic [1:0] pins_out,
  input  wire logic [1:0] pins_oe,
  input  wire logic [1:0] cond_lvl,
  output logic      [1:0] pins_in
);
  // resolve each wire from the enables so the bench sees the true level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pins_in[i] = pins_oe[i] ? pins_out[i] : cond_lvl[i];
    end
  end
endmodule : bic_far_end
